// *** common/tw_consts.svh ***
// Constants of the two-wire bus controller: timing, bit positions, widths.
// Assumes the link clock period below; counts are derived from it.
`ifndef TW_CONSTS_SVH
`define TW_CONSTS_SVH

// Link clock period in ns
`define TW_LINK_PERIOD_NS 30
// Least clock low and high times of a standard-mode bit, in ns
`define TW_T_LOW_NS 4700
`define TW_T_HIGH_NS 4000
// Least times round up to whole link clock cycles
`define TW_LOW_CYC ((`TW_T_LOW_NS + `TW_LINK_PERIOD_NS - 1) / `TW_LINK_PERIOD_NS)
`define TW_HIGH_CYC ((`TW_T_HIGH_NS + `TW_LINK_PERIOD_NS - 1) / `TW_LINK_PERIOD_NS)
// Width of the hung-bus time-out counter
`define TW_TOUT_W 14
// Bit index of the read/write flag, the acknowledge bit, the frame end
`define TW_BIT_RW 4'h7
`define TW_BIT_ACK 4'h8
`define TW_BIT_END 4'h9
// Width of the device's own bus address
`define TW_ADDR_W 7

`endif

// *** common/tw_pkg.sv ***
// Types of the two-wire bus controller: engine states and user commands.
// Assumes nothing of its surroundings.
package tw_pkg;

    // Bus engine states, link clock domain
    typedef enum logic [2:0] {
        TW_IDLE = 3'h0,
        TW_START = 3'h1,
        TW_LOW = 3'h2,
        TW_HIGH = 3'h3,
        TW_HOLD = 3'h4,
        TW_STOP = 3'h5,
        TW_SLAVE = 3'h6
    } tw_state_t;

    // User commands
    typedef enum logic [1:0] {
        TW_OP_START = 2'h0,
        TW_OP_WRITE = 2'h1,
        TW_OP_READ = 2'h2,
        TW_OP_STOP = 2'h3
    } tw_op_t;

endpackage : tw_pkg

// *** verification/test_tw_ctrl.sv ***
// Bench: master writes, stretching, time-out, arbitration loss.
// Assumes the slave model and pull-ups on both wires.
`timescale 1ns/10ps
`default_nettype none
module test_tw_ctrl;
    import tw_pkg::*;
    typedef struct {tw_op_t op; logic [7:0] d; logic ack;} tw_row_t;
    logic mclk = 0, link_clk = 0, rst_n = 0, en = 0, valid = 0;
    logic ack_en = 1, hold_scl = 0, pull_sda = 0, tclr = 0;
    tw_op_t op = TW_OP_STOP;
    logic [7:0] data = 8'h00, got, rx;
    logic ready, done, acks, lost, oe_c, oe_d, m_oe, tflag, so_c, so_d;
    int errors = 0, total_checks = 0, cyc = 0;
    wire logic scl = !(oe_c | hold_scl);
    wire logic sda = !(oe_d | m_oe | pull_sda);
    tw_row_t rows [4] = '{'{TW_OP_START, 8'hA4, 1}, '{TW_OP_WRITE, 8'h5A, 1},
        '{TW_OP_WRITE, 8'h81, 0}, '{TW_OP_STOP, 8'h00, 1}};
    // Short counts keep the run brief
    tw_ctrl #(.TOUT_W(6), .LOW_CYC(9), .HIGH_CYC(8)) u_dut (.mclk(mclk),
        .rst_n(rst_n), .link_clk(link_clk), .port_enable_bit(en),
        .own_addr(7'h11), .cmd_valid(valid), .cmd_op(op), .cmd_data(data),
        .cmd_ack(1'b0), .cmd_ready(ready), .done(done), .rx_data(rx),
        .ack_seen(acks), .arb_lost(lost), .slave_sel(), .slave_read(),
        .timeout_flag(tflag), .timeout_clear(tclr), .scl_in(scl),
        .sda_in(sda), .scl_out(so_c), .scl_oe(oe_c), .sda_out(so_d),
        .sda_oe(oe_d));
    tw_slave_model u_slave (.scl(scl), .sda(sda), .ack_en(ack_en),
        .sda_oe(m_oe), .got(got));
    initial forever #50 mclk = ~mclk;
    // Link clock, phase unrelated
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end
    // Hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One command, valid for one mclk cycle, then wait for done
    task automatic cmd(input tw_op_t o, input logic [7:0] d);
        @(negedge mclk);
        op = o;
        data = d;
        valid = 1;
        @(negedge mclk);
        valid = 0;
        while (done !== 1'b1) @(negedge mclk);
    endtask : cmd
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (12) @(negedge mclk);
        rst_n = 1;
        check({3'h0, ready, done, oe_c, oe_d, tflag}, 8'h10);
        en = 1;
        repeat (4) @(negedge mclk);
        foreach (rows[i]) begin
            ack_en = rows[i].ack;
            cmd(rows[i].op, rows[i].d);
            if (rows[i].op != TW_OP_STOP) begin
                check(got, rows[i].d);
                check(rx, rows[i].d);
                check({7'h00, acks}, 8'(rows[i].ack));
            end else check({6'h00, scl, sda}, 8'h03);
            $display("row %0d done", i);
        end
        // Far side stretches the clock mid-frame
        cmd(TW_OP_START, 8'hA4);
        hold_scl = 1;
        fork
            cmd(TW_OP_WRITE, 8'h3C);
            begin
                repeat (40) @(negedge mclk);
                check({7'h00, ready}, 8'h00);
                hold_scl = 0;
            end
        join
        check(got, 8'h3C);
        cmd(TW_OP_STOP, 8'h00);
        $display("stretch done");
        // Stuck clock line trips the time-out
        hold_scl = 1;
        repeat (40) @(negedge mclk);
        check({7'h00, tflag}, 8'h00);
        repeat (40) @(negedge mclk);
        check({7'h00, tflag}, 8'h01);
        hold_scl = 0;
        tclr = 1;
        @(negedge mclk);
        tclr = 0;
        @(negedge mclk);
        check({7'h00, tflag}, 8'h00);
        $display("timeout done");
        // Rival master keeps data low
        fork
            cmd(TW_OP_START, 8'hFF);
            begin
                do @(negedge mclk); while (oe_c !== 1'b1);
                pull_sda = 1;
            end
        join
        check({4'h0, so_c, so_d, lost, oe_d}, 8'h02);
        pull_sda = 0;
        $display("arbitration done");
        // Another master's START: engine follows as slave, then STOP
        repeat (10) @(negedge mclk);
        pull_sda = 1;
        repeat (10) @(negedge mclk);
        check({7'h00, ready}, 8'h01);
        pull_sda = 0;
        repeat (10) @(negedge mclk);
        $display("foreign start done");
        give_verdict();
    end
endmodule : test_tw_ctrl
`default_nettype wire

// *** verification/tw_slave_model.sv ***
// Slave on the shared lines: shifts bytes in, answers bit nine.
// Assumes the bench resolves both wires with pull-ups.
`timescale 1ns/10ps
`default_nettype none
module tw_slave_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic ack_en,
    output logic sda_oe,
    output logic [7:0] got
);
    int cnt = 0; // Bits seen in this byte
    initial sda_oe = 1'b0;
    // START restarts the byte
    always @(negedge sda) if (scl) cnt = 0;
    // Sample while clock high, MSB first
    always @(posedge scl) begin
        if (cnt < 8) got = {got[6:0], sda};
        cnt = cnt + 1;
    end
    // Only moves data in the low phase
    always @(negedge scl) begin
        sda_oe <= (cnt == 8) && ack_en;
        if (cnt == 9) cnt = 0;
    end
endmodule : tw_slave_model
`default_nettype wire

// *** verilog/tw_ctrl.sv ***
// Two-wire bus controller, master and slave, with hung-bus time-out.
// Assumes open-drain pads outside; own_addr is static while enabled.
`include "tw_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module tw_ctrl #(
    parameter int TOUT_W = `TW_TOUT_W,
    parameter int LOW_CYC = `TW_LOW_CYC,
    parameter int HIGH_CYC = `TW_HIGH_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic port_enable_bit,
    input wire logic [`TW_ADDR_W-1:0] own_addr,
    input wire logic cmd_valid,
    input wire tw_pkg::tw_op_t cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_ack,
    output logic cmd_ready,
    output logic done,
    output logic [7:0] rx_data,
    output logic ack_seen,
    output logic arb_lost,
    output logic slave_sel,
    output logic slave_read,
    output logic timeout_flag,
    input wire logic timeout_clear,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe
);
    import tw_pkg::*;

    // Phase ends, cast to the counter width
    localparam logic [7:0] LOW_END = 8'(LOW_CYC - 1);
    localparam logic [7:0] HIGH_END = 8'(HIGH_CYC - 1);

    // Level of the line this bit: 1 means released
    function automatic logic tw_release(input logic tx,
                                        input logic [3:0] bc,
                                        input logic [7:0] sh,
                                        input logic ackb);
        if (bc < `TW_BIT_ACK) begin
            return tx ? sh[7] : 1'b1; // MSB of byte, or let sender drive
        end
        return tx ? 1'b1 : ~ackb; // Receiver answers in bit nine
    endfunction : tw_release

    // ---------------- mclk domain ----------------
    logic req_tgl; // Command toggle towards link side
    tw_op_t hold_op; // Command words held stable for the link side
    logic [7:0] hold_data;
    logic hold_ack;
    logic m_scl, m_sda, done_s; // Synchronised in mclk domain
    logic m_scl_d, m_sda_d; // Previous line levels
    logic done_seen; // Last done toggle seen
    logic [TOUT_W-1:0] tcnt; // Hung-bus counter
    logic activity; // Any line change
    logic bus_idle; // Both lines high

    // ---------------- link domain ----------------
    logic scl_s, sda_s, en_s, req_s; // Synchronised in link domain
    logic scl_d, sda_d; // Previous line levels
    logic req_seen; // Last command toggle taken
    logic bus_busy; // Between START and STOP
    tw_state_t state;
    logic [7:0] cnt; // Phase timer
    logic [3:0] bitcnt; // Bit within the nine-bit frame
    logic [7:0] sh; // Shift register, out at bit 7, in at bit 0
    logic tx; // Sending this frame
    logic master; // Role of the current transfer
    logic addr_phase; // Slave is taking an address byte
    logic ack_bit; // Acknowledge to give when receiving
    logic done_tgl; // Result toggle towards mclk side
    logic [7:0] res_data; // Results, stable while done_tgl settles
    logic res_ack, res_lost, res_sel, res_rd;
    logic start_det, stop_det, scl_rise, scl_fall, cmd_new, lost_now;
    logic bit_end; // Master high phase over

    tw_sync #(.W(3)) u_msync (
        .clk(mclk),
        .rst_n(rst_n),
        .d({scl_in, sda_in, done_tgl}),
        .q({m_scl, m_sda, done_s})
    );

    tw_sync #(.W(4)) u_lsync (
        .clk(link_clk),
        .rst_n(rst_n),
        .d({scl_in, sda_in, port_enable_bit, req_tgl}),
        .q({scl_s, sda_s, en_s, req_s})
    );

    // Command intake; one command in flight, words held until done
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            req_tgl <= 1'b0;
            hold_op <= TW_OP_STOP;
            hold_data <= 8'h00;
            hold_ack <= 1'b0;
            cmd_ready <= 1'b1;
        end else if (cmd_valid && cmd_ready) begin
            req_tgl <= ~req_tgl;
            hold_op <= cmd_op;
            hold_data <= cmd_data;
            hold_ack <= cmd_ack;
            cmd_ready <= 1'b0;
        end else if (done_s != done_seen) begin
            cmd_ready <= 1'b1;
        end
    end

    // Results come over once the done toggle has crossed
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            done_seen <= 1'b0;
            done <= 1'b0;
            rx_data <= 8'h00;
            ack_seen <= 1'b0;
            arb_lost <= 1'b0;
            slave_sel <= 1'b0;
            slave_read <= 1'b0;
        end else begin
            done_seen <= done_s;
            done <= done_s != done_seen;
            if (done_s != done_seen) begin
                rx_data <= res_data;
                ack_seen <= res_ack;
                arb_lost <= res_lost;
                slave_sel <= res_sel;
                slave_read <= res_rd;
            end
        end
    end

    assign activity = (m_scl != m_scl_d) || (m_sda != m_sda_d);
    assign bus_idle = m_scl && m_sda;

    // Time-out: counts only while a line sits low with nothing moving
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            m_scl_d <= 1'b1;
            m_sda_d <= 1'b1;
            tcnt <= '0;
        end else begin
            m_scl_d <= m_scl;
            m_sda_d <= m_sda;
            if (!port_enable_bit || activity || bus_idle) begin
                tcnt <= '0;
            end else begin
                tcnt <= tcnt + 1'b1; // Wraps after overflow; flag stays
            end
        end
    end

    // Sticky time-out request; a new overflow beats the clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timeout_flag <= 1'b0;
        end else if (port_enable_bit && !activity && !bus_idle &&
                     (&tcnt)) begin
            timeout_flag <= 1'b1;
        end else if (timeout_clear || !port_enable_bit) begin
            timeout_flag <= 1'b0;
        end
    end

    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det = scl_s && scl_d && !sda_d && sda_s;
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign cmd_new = req_s != req_seen;
    assign lost_now = (state == TW_HIGH) && (cnt == 8'h00) && scl_s &&
                      tx && (bitcnt < `TW_BIT_ACK) && !sda_oe && !sda_s;
    assign bit_end = (state == TW_HIGH) && (cnt != 8'h00) &&
                     (!scl_s || cnt == HIGH_END);

    // Line history and bus busy tracking
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            bus_busy <= 1'b0;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            if (start_det) begin
                bus_busy <= 1'b1;
            end else if (stop_det) begin
                bus_busy <= 1'b0;
            end
        end
    end

    // Pads are open drain: the driven level is always low
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    // Bus engine: master and slave share one frame machine
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= TW_IDLE;
            cnt <= 8'h00;
            bitcnt <= 4'h0;
            sh <= 8'hFF;
            tx <= 1'b0;
            master <= 1'b0;
            addr_phase <= 1'b0;
            ack_bit <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            req_seen <= 1'b0;
            done_tgl <= 1'b0;
            res_data <= 8'h00;
            res_ack <= 1'b0;
            res_lost <= 1'b0;
            res_sel <= 1'b0;
            res_rd <= 1'b0;
        end else if (!en_s) begin
            // Disabled: let go of both lines, drop pending commands
            state <= TW_IDLE;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            master <= 1'b0;
            if (cmd_new) begin
                req_seen <= req_s;
                done_tgl <= ~done_tgl;
            end
        end else begin
            case (state)
                TW_IDLE: begin
                    if (cmd_new && (hold_op != TW_OP_START ||
                        (!bus_busy && scl_s && sda_s))) begin
                        req_seen <= req_s;
                        res_lost <= 1'b0;
                        res_sel <= 1'b0;
                        if (hold_op == TW_OP_START) begin
                            sh <= hold_data;
                            tx <= 1'b1;
                            master <= 1'b1;
                            sda_oe <= 1'b1; // START: data falls, clock high
                            cnt <= 8'h00;
                            state <= TW_START;
                        end else begin
                            done_tgl <= ~done_tgl; // Nothing to do idle
                        end
                    end else if (start_det) begin
                        master <= 1'b0;
                        tx <= 1'b0;
                        addr_phase <= 1'b1;
                        bitcnt <= 4'h0;
                        state <= TW_SLAVE;
                    end
                end
                TW_START: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == HIGH_END) begin
                        scl_oe <= 1'b1;
                        cnt <= 8'h00;
                        bitcnt <= 4'h0;
                        state <= TW_LOW;
                    end
                end
                TW_LOW: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == 8'h00) begin
                        sda_oe <= ~tw_release(tx, bitcnt, sh, ack_bit);
                    end
                    if (cnt == LOW_END) begin
                        scl_oe <= 1'b0;
                        cnt <= 8'h00;
                        state <= TW_HIGH;
                    end
                end
                TW_HIGH: begin
                    if (lost_now) begin
                        // Another master drove low where we sent high
                        res_lost <= 1'b1;
                        res_data <= sh;
                        master <= 1'b0;
                        sda_oe <= 1'b0;
                        done_tgl <= ~done_tgl;
                        state <= TW_IDLE;
                    end else if (bit_end) begin
                        scl_oe <= 1'b1;
                        cnt <= 8'h00;
                        bitcnt <= bitcnt + 4'h1;
                        if (bitcnt == `TW_BIT_ACK) begin
                            res_data <= sh;
                            done_tgl <= ~done_tgl;
                            state <= TW_HOLD;
                        end else begin
                            state <= TW_LOW;
                        end
                    end else if (scl_s) begin
                        // Clock seen high: sample once, then time high
                        cnt <= cnt + 8'h01;
                        if (cnt == 8'h00) begin
                            if (bitcnt < `TW_BIT_ACK) begin
                                sh <= {sh[6:0], sda_s};
                            end else begin
                                res_ack <= ~sda_s;
                            end
                        end
                    end
                    // Clock held low by others: wait with cnt at zero
                end
                TW_HOLD: begin
                    // Clock held low until the user gives the next byte
                    scl_oe <= 1'b1;
                    sda_oe <= 1'b0;
                    if (cmd_new) begin
                        req_seen <= req_s;
                        bitcnt <= 4'h0;
                        cnt <= 8'h00;
                        addr_phase <= 1'b0;
                        if (hold_op == TW_OP_WRITE ||
                            hold_op == TW_OP_READ) begin
                            tx <= hold_op == TW_OP_WRITE;
                            sh <= (hold_op == TW_OP_WRITE) ? hold_data :
                                                             8'hFF;
                            ack_bit <= hold_ack;
                            if (master) begin
                                state <= TW_LOW;
                            end else begin
                                // Slave: first bit out and clock freed on the same edge
                                sda_oe <= (hold_op == TW_OP_WRITE) &&
                                          !hold_data[7];
                                scl_oe <= 1'b0;
                                state <= TW_SLAVE;
                            end
                        end else if (hold_op == TW_OP_STOP && master) begin
                            sda_oe <= 1'b1;
                            state <= TW_STOP;
                        end else if (hold_op == TW_OP_STOP) begin
                            scl_oe <= 1'b0; // Slave lets the bus go
                            state <= TW_IDLE;
                        end else begin
                            done_tgl <= ~done_tgl; // START here is ignored
                        end
                    end
                end
                TW_STOP: begin
                    if (scl_oe) begin
                        cnt <= cnt + 8'h01;
                        if (cnt == LOW_END) begin
                            scl_oe <= 1'b0;
                            cnt <= 8'h00;
                        end
                    end else if (scl_s) begin
                        cnt <= cnt + 8'h01;
                        if (cnt == HIGH_END) begin
                            sda_oe <= 1'b0; // STOP: data rises, clock high
                            master <= 1'b0;
                            done_tgl <= ~done_tgl;
                            state <= TW_IDLE;
                        end
                    end
                end
                TW_SLAVE: begin
                    if (stop_det) begin
                        sda_oe <= 1'b0;
                        state <= TW_IDLE;
                    end else if (start_det) begin
                        sda_oe <= 1'b0;
                        tx <= 1'b0;
                        addr_phase <= 1'b1;
                        bitcnt <= 4'h0;
                    end else if (scl_rise) begin
                        bitcnt <= bitcnt + 4'h1;
                        if (bitcnt < `TW_BIT_ACK) begin
                            sh <= {sh[6:0], sda_s};
                        end else begin
                            res_ack <= ~sda_s;
                        end
                        if (addr_phase && bitcnt == `TW_BIT_RW) begin
                            ack_bit <= sh[6:0] == own_addr;
                            res_rd <= sda_s;
                        end
                    end else if (scl_fall) begin
                        if (bitcnt == `TW_BIT_END) begin
                            if (addr_phase && !ack_bit) begin
                                sda_oe <= 1'b0; // Not us: stand aside
                                state <= TW_IDLE;
                            end else begin
                                scl_oe <= 1'b1;
                                res_sel <= 1'b1;
                                res_data <= sh;
                                done_tgl <= ~done_tgl;
                                state <= TW_HOLD;
                            end
                        end else begin
                            sda_oe <= ~tw_release(tx, bitcnt, sh, ack_bit);
                        end
                    end
                end
                default: begin
                    state <= TW_IDLE;
                end
            endcase
        end
    end

    // Time-out and command handoff checks, mclk domain
    a_tout_overflow: assert property (@(posedge mclk) disable iff (!rst_n)
        (port_enable_bit && !activity && !bus_idle && (&tcnt))
        |=> timeout_flag) else $error("time-out overflow not flagged");
    a_tout_restart: assert property (@(posedge mclk) disable iff (!rst_n)
        (activity || !port_enable_bit) |=> tcnt == '0)
        else $error("time-out counter not restarted");
    a_cmd_handoff: assert property (@(posedge mclk) disable iff (!rst_n)
        (cmd_valid && cmd_ready) |=> !cmd_ready && $changed(req_tgl))
        else $error("command not handed to bus engine");

    // Bus checks, link domain
    sequence s_msb_drive;
        state == TW_LOW && cnt == 8'h00 && tx && bitcnt < `TW_BIT_ACK;
    endsequence
    sequence s_last_bit_end;
        bit_end && bitcnt == `TW_BIT_ACK;
    endsequence
    sequence s_stretched;
        state == TW_HIGH && cnt == 8'h00 && !scl_s && !lost_now;
    endsequence

    a_msb_first: assert property (@(posedge link_clk) disable iff (!rst_n)
        s_msb_drive |=> sda_oe == !$past(sh[7]))
        else $error("data bit is not the top of the shift register");
    a_nine_bits: assert property (@(posedge link_clk) disable iff (!rst_n)
        s_last_bit_end |=> state == TW_HOLD && scl_oe && bitcnt == 4'h9)
        else $error("frame did not end after the acknowledge bit");
    a_data_steady: assert property (@(posedge link_clk) disable iff (!rst_n)
        (state == TW_HIGH && scl_s && scl_d && !lost_now) |=> $stable(sda_oe))
        else $error("data line moved while clock high");
    a_arb_withdraw: assert property (@(posedge link_clk) disable iff (!rst_n)
        lost_now |=> state == TW_IDLE && !sda_oe && !master ##1 !scl_oe)
        else $error("losing master did not withdraw");
    a_stretch_wait: assert property (@(posedge link_clk) disable iff (!rst_n)
        s_stretched |=> state == TW_HIGH && cnt == 8'h00)
        else $error("transfer ran on while clock held low");
    a_slave_start: assert property (@(posedge link_clk) disable iff (!rst_n)
        (en_s && state == TW_IDLE && start_det && !cmd_new) |=>
        state == TW_SLAVE && addr_phase && bitcnt == 4'h0)
        else $error("START by another master not followed");
    a_low_time: assert property (@(posedge link_clk) disable iff (!rst_n)
        (en_s && state == TW_LOW && cnt == 8'h00) |-> scl_oe [*8])
        else $error("clock low phase cut short");

endmodule : tw_ctrl

`default_nettype wire

// *** verilog/tw_sync.sv ***
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a level; multi-bit words must not be passed here.
`timescale 1ns/10ps
`default_nettype none

module tw_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta; // First stage, read only by the second

    // Two stages; only q is seen by other logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule : tw_sync

`default_nettype wire
